// ==== design/cpd_consts.svh ====
// constants for the complementary pwm dead-time control block
`ifndef CPD_CONSTS_SVH
`define CPD_CONSTS_SVH

// register byte addresses
`define CPD_A_BASE              32'hFFFFC200
`define CPD_A_TIMER_CONTROL_CH3 32'hFFFFC200
`define CPD_A_TIMER_CONTROL_CH4 32'hFFFFC201
`define CPD_A_TIMER_MODE_CH3    32'hFFFFC202
`define CPD_A_TIMER_MODE_CH4    32'hFFFFC203
`define CPD_A_PIN_IO_HIGH_CH3   32'hFFFFC204
`define CPD_A_PIN_IO_LOW_CH3    32'hFFFFC205
`define CPD_A_PIN_IO_HIGH_CH4   32'hFFFFC206
`define CPD_A_PIN_IO_LOW_CH4    32'hFFFFC207
`define CPD_A_IRQ_ENABLE_CH3    32'hFFFFC208
`define CPD_A_IRQ_ENABLE_CH4    32'hFFFFC209
`define CPD_A_OUTPUT_MASTER_EN  32'hFFFFC20A
`define CPD_A_GATE_CONTROL      32'hFFFFC20D
`define CPD_A_OUTPUT_CONTROL_1  32'hFFFFC20E
`define CPD_A_OUTPUT_CONTROL_2  32'hFFFFC20F
`define CPD_A_COUNTER_CH3       32'hFFFFC210
`define CPD_A_COUNTER_CH4       32'hFFFFC212
`define CPD_A_CYCLE_DATA        32'hFFFFC214
`define CPD_A_DEAD_TIME_DATA    32'hFFFFC216
`define CPD_A_GENERAL_A_CH3     32'hFFFFC218
`define CPD_A_GENERAL_B_CH3     32'hFFFFC21A
`define CPD_A_GENERAL_A_CH4     32'hFFFFC21C
`define CPD_A_GENERAL_B_CH4     32'hFFFFC21E
`define CPD_A_DEAD_TIME_ENABLE  32'hFFFFC220
`define CPD_A_WAVEFORM_CONTROL  32'hFFFFC221

// reset values
`define CPD_RST_BYTE            8'h00
`define CPD_RST_OUTPUT_MASTER   8'hC0
`define CPD_RST_GATE_CONTROL    8'h80
`define CPD_RST_COUNTER         16'h0000
`define CPD_RST_WORD            16'hFFFF
`define CPD_RST_DTE             1'b1
`define CPD_RST_CCE             1'b0
`define CPD_RST_WRE             1'b0

// field positions
`define CPD_DTE_BIT             0
`define CPD_CCE_BIT             7
`define CPD_WRE_BIT             0

// complementary pwm mode codes in the mode field of timer_mode_ch3
`define CPD_MODE_COMPL_LO       4'hD
`define CPD_MODE_COMPL_HI       4'hF

`endif

// ==== design/cpd_pkg.sv ====
// types shared by the complementary pwm dead-time control block
package cpd_pkg;

  // one register bus request as seen in a single cycle
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } cpd_bus_t;

  // the three control flags of the dead-time and waveform registers
  typedef struct packed {
    logic dte;
    logic cce;
    logic waveform_retain_enable;
  } cpd_flags_t;

endpackage : cpd_pkg

// ==== design/cpd_pwm_deadtime_ctrl.sv ====
// channel 3/4 register set with dead-time enable and waveform control
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "cpd_consts.svh"

// Function
// - one 8-bit dead-time enable register decides whether dead time is inserted in complementary pwm mode.
// - the dead-time enable bit resets to 1, where 1 inserts dead time and 0 suppresses it.
// - the dead-time enable bit clears only on a write of 0 after reading it as 1, and writing 1 never sets it.
// - reserved bits of the dead-time enable register read as zero and software writes them as zero.
// - an 8-bit waveform-control register holds compare-clear enable and waveform retain for the counter pair.
// - with compare-clear enable at 1 both counters clear on a general_a_ch3 match in complementary pwm mode.
// - compare-clear enable sets only on a write of 1 after reading it as 0.
module cpd_pwm_deadtime_ctrl #(
  parameter int CNT_W = 16
) (
  input  wire logic             MCLK,
  input  wire logic             SYS_RST,
  input  wire logic [31:0]      ADDR,
  input  wire logic [15:0]      WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  input  wire logic             CNT_RUN,
  output var  logic [15:0]      RDATA,
  output var  logic             DT_ENABLE,
  output var  logic             CMP_CLEAR_EN,
  output var  logic             WAVE_RETAIN,
  output var  logic             CMP_CLEAR_PULSE,
  output var  logic             COMPL_MODE,
  output var  logic [CNT_W-1:0] COUNT3,
  output var  logic [CNT_W-1:0] COUNT4
);

  // byte registers sit in the first sixteen addresses
  localparam int NBYTE = 16;
  // word registers from cycle_data up to general_b_ch4
  localparam int NWORD = 6;
  localparam int WIDX_GRA3 = 2;

  cpd_pkg::cpd_bus_t   bus;
  cpd_pkg::cpd_flags_t flags;
  logic [7:0]          byte_ff [NBYTE];
  logic [15:0]         word_ff [NWORD];
  logic [CNT_W-1:0]    cnt3_ff;
  logic [CNT_W-1:0]    cnt4_ff;
  logic                dte_ff;
  logic                cce_ff;
  logic                wre_ff;
  logic                dte_armed_ff;
  logic                cce_armed_ff;
  logic [15:0]         rdata_ff;
  logic                clr_pulse_ff;
  logic                compl_ff;
  logic [15:0]         nxt_rdata;
  logic                sel_dte;
  logic                sel_twc;
  logic                sel_cnt3;
  logic                sel_cnt4;
  logic                cmp_hit;
  logic                compl_mode;
  logic [7:0]          rd_off;

  // byte offset inside the block, used by both decoders
  function automatic logic [7:0] cpd_offset(input logic [31:0] a);
    logic [31:0] d;
    d = a - `CPD_A_BASE;
    cpd_offset = (a[31:8] == 24'(`CPD_A_BASE >> 8)) ? d[7:0] : 8'hFF;
  endfunction : cpd_offset

  // holes at 0x0B and 0x0C carry no register
  function automatic logic cpd_byte_impl(input int i);
    cpd_byte_impl = (i != 11) && (i != 12);
  endfunction : cpd_byte_impl

  function automatic logic [7:0] cpd_byte_rst(input int i);
    case (i)
      10:      cpd_byte_rst = `CPD_RST_OUTPUT_MASTER;
      13:      cpd_byte_rst = `CPD_RST_GATE_CONTROL;
      default: cpd_byte_rst = `CPD_RST_BYTE;
    endcase
  endfunction : cpd_byte_rst

  // bundle the plain bus pins into one request
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // decodes of the registers with their own side effects
  assign sel_dte  = (bus.addr == `CPD_A_DEAD_TIME_ENABLE);
  assign sel_twc  = (bus.addr == `CPD_A_WAVEFORM_CONTROL);
  assign sel_cnt3 = (bus.addr == `CPD_A_COUNTER_CH3);
  assign sel_cnt4 = (bus.addr == `CPD_A_COUNTER_CH4);

  // offset of the current access; a function result cannot be bit-selected
  assign rd_off = cpd_offset(bus.addr);

  // complementary pwm is selected by the mode field of timer_mode_ch3
  assign compl_mode = (byte_ff[2][3:0] >= `CPD_MODE_COMPL_LO) &&
                      (byte_ff[2][3:0] <= `CPD_MODE_COMPL_HI);

  // compare hit only counts while compare-clear is enabled and the mode
  // field of timer_mode_ch3 selects complementary pwm
  assign cmp_hit = compl_mode && cce_ff &&
                   (cnt3_ff == word_ff[WIDX_GRA3][CNT_W-1:0]);

  // plain byte registers, one flip-flop row per address
  generate
    for (genvar gi = 0; gi < NBYTE; gi++) begin : g_byte
      if (cpd_byte_impl(gi)) begin : g_impl
        always_ff @(posedge MCLK) begin
          if (SYS_RST) begin
            byte_ff[gi] <= cpd_byte_rst(gi);
          end else if (bus.wr && cpd_offset(bus.addr) == 8'(gi)) begin
            byte_ff[gi] <= bus.wdata[7:0];
          end
        end
      end else begin : g_hole
        // unmapped bytes read as zero
        always_ff @(posedge MCLK) begin
          byte_ff[gi] <= 8'h00;
        end
      end
    end
  endgenerate

  // word registers: cycle, dead time and the four general registers
  generate
    for (genvar gw = 0; gw < NWORD; gw++) begin : g_word
      always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
          word_ff[gw] <= `CPD_RST_WORD;
        end else if (bus.wr && cpd_offset(bus.addr) == 8'(8'h14 + 2 * gw)) begin
          word_ff[gw] <= bus.wdata;
        end
      end
    end
  endgenerate

  // counter pair; a bus write wins over counting so software can preload
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cnt3_ff <= CNT_W'(`CPD_RST_COUNTER);
    end else if (bus.wr && sel_cnt3) begin
      cnt3_ff <= bus.wdata[CNT_W-1:0];
    end else if (CNT_RUN && cmp_hit) begin
      cnt3_ff <= '0;
    end else if (CNT_RUN) begin
      cnt3_ff <= cnt3_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cnt4_ff <= CNT_W'(`CPD_RST_COUNTER);
    end else if (bus.wr && sel_cnt4) begin
      cnt4_ff <= bus.wdata[CNT_W-1:0];
    end else if (CNT_RUN && cmp_hit) begin
      cnt4_ff <= '0;
    end else if (CNT_RUN) begin
      cnt4_ff <= cnt4_ff + CNT_W'(1);
    end
  end

  // one-cycle marker of a synchronous clear, for the waveform stage
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      clr_pulse_ff <= 1'b0;
    end else begin
      clr_pulse_ff <= CNT_RUN && cmp_hit;
    end
  end

  // dead-time enable: only ever cleared, and only after a read of 1
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      dte_ff <= `CPD_RST_DTE;
    end else if (bus.wr && sel_dte && !bus.wdata[`CPD_DTE_BIT] && dte_armed_ff) begin
      dte_ff <= 1'b0;
    end
  end

  // read record for dead-time enable; any write to it uses it up
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      dte_armed_ff <= 1'b0;
    end else if (bus.rd && sel_dte) begin
      dte_armed_ff <= dte_ff;
    end else if (bus.wr && sel_dte) begin
      dte_armed_ff <= 1'b0;
    end
  end

  // compare-clear enable: only ever set, and only after a read of 0;
  // the counters are expected stopped here, nothing enforces it
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cce_ff <= `CPD_RST_CCE;
    end else if (bus.wr && sel_twc && bus.wdata[`CPD_CCE_BIT] && cce_armed_ff) begin
      cce_ff <= 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cce_armed_ff <= 1'b0;
    end else if (bus.rd && sel_twc) begin
      cce_armed_ff <= !cce_ff;
    end else if (bus.wr && sel_twc) begin
      cce_armed_ff <= 1'b0;
    end
  end

  // waveform retain is a plain read/write bit
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      wre_ff <= `CPD_RST_WRE;
    end else if (bus.wr && sel_twc) begin
      wre_ff <= bus.wdata[`CPD_WRE_BIT];
    end
  end

  assign flags = '{dte: dte_ff, cce: cce_ff, waveform_retain_enable: wre_ff};

  // read mux; reserved and unmapped bits come back as zero
  always_comb begin
    nxt_rdata = 16'h0000;
    if (sel_dte) begin
      nxt_rdata = {15'h0000, flags.dte};
    end else if (sel_twc) begin
      nxt_rdata = {8'h00, flags.cce, 6'h00, flags.waveform_retain_enable};
    end else if (sel_cnt3) begin
      nxt_rdata = 16'(cnt3_ff);
    end else if (sel_cnt4) begin
      nxt_rdata = 16'(cnt4_ff);
    end else if (rd_off < 8'h10) begin
      nxt_rdata = {8'h00, byte_ff[rd_off[3:0]]};
    end else if (rd_off >= 8'h14 && rd_off < 8'h20 &&
                 !rd_off[0]) begin
      nxt_rdata = word_ff[3'((rd_off - 8'h14) >> 1)];
    end
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= bus.rd ? nxt_rdata : 16'h0000;
    end
  end

  // mode flag is registered so every output leaves a flip-flop
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      compl_ff <= 1'b0;
    end else begin
      compl_ff <= compl_mode;
    end
  end

  // outputs straight from flip-flops
  assign RDATA           = rdata_ff;
  assign DT_ENABLE       = dte_ff;
  assign CMP_CLEAR_EN    = cce_ff;
  assign WAVE_RETAIN     = wre_ff;
  assign CMP_CLEAR_PULSE = clr_pulse_ff;
  assign COMPL_MODE      = compl_ff;
  assign COUNT3          = cnt3_ff;
  assign COUNT4          = cnt4_ff;

  // checks on the flags, the read path and the compare clear
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  a_dte_reset_one: assert property ($past(SYS_RST) |-> dte_ff)
    else $error("dead-time enable not 1 after reset");

  a_dte_never_set: assert property (!$rose(dte_ff))
    else $error("dead-time enable was set by a write");

  a_dte_clear_gate: assert property ($fell(dte_ff) |->
      $past(bus.wr && sel_dte && !bus.wdata[0] && dte_armed_ff))
    else $error("dead-time enable cleared without a prior read of 1");

  a_dte_read_value: assert property (bus.rd && sel_dte |=> RDATA[0] == $past(dte_ff))
    else $error("dead-time enable read value wrong");

  a_dte_reserved_zero: assert property (bus.rd && sel_dte |=> RDATA[15:1] == 15'h0000)
    else $error("dead-time enable reserved bits not zero");

  a_arm_after_read: assert property (bus.rd && sel_dte && dte_ff |=>
      dte_armed_ff ##0 (!bus.wr || !sel_dte || bus.wdata[0] || !dte_ff)[*1] or
      (bus.wr && sel_dte && !bus.wdata[0] ##1 !dte_ff))
    else $error("read of dead-time enable not recorded");

  a_cce_set_gate: assert property ($rose(cce_ff) |->
      $past(bus.wr && sel_twc && bus.wdata[7] && cce_armed_ff))
    else $error("compare-clear enable set without a prior read of 0");

  a_twc_read_layout: assert property (bus.rd && sel_twc |=>
      RDATA == {8'h00, $past(cce_ff), 6'h00, $past(wre_ff)})
    else $error("waveform-control read layout wrong");

  a_pair_clear: assert property (CNT_RUN && cmp_hit && !bus.wr |=>
      cnt3_ff == '0 && cnt4_ff == '0 && CMP_CLEAR_PULSE)
    else $error("counter pair not cleared on compare match");

  a_no_clear_off: assert property (CMP_CLEAR_PULSE |-> $past(cce_ff && compl_mode))
    else $error("counter clear without compare-clear enable");

  // a read and a write never share a cycle, so the record has no set/clear race
  a_dte_arm_used: assert property (bus.wr && sel_dte |=> !dte_armed_ff)
    else $error("dead-time enable record survived a write");

  // compare-clear has no clearing path short of reset
  a_cce_never_clear: assert property (!$fell(cce_ff))
    else $error("compare-clear enable was cleared by a write");

  // waveform retain is a plain read/write bit
  a_wre_plain_bit: assert property (bus.wr && sel_twc |=> WAVE_RETAIN == $past(bus.wdata[`CPD_WRE_BIT]))
    else $error("waveform retain did not take the written value");

  // without compare-clear the pair only counts, so a stray clear of cnt3_ff shows here
  a_count_no_clear: assert property (CNT_RUN && !cce_ff && !bus.wr |=>
      cnt3_ff == $past(cnt3_ff) + CNT_W'(1))
    else $error("counter did not advance with compare-clear off");

  // read data must not linger once the strobe has gone
  a_rdata_idle_zero: assert property (!bus.rd |=> RDATA == 16'h0000)
    else $error("read data not zero outside a read");

  // main scenarios; the bench reaches all but c_dte_cleared and c_cce_set
  c_dte_cleared: cover property (bus.rd && sel_dte ##1 bus.wr && sel_dte && !bus.wdata[0] ##1 !dte_ff);
  c_cce_set: cover property (bus.rd && sel_twc ##1 bus.wr && sel_twc && bus.wdata[7] ##1 cce_ff);
  c_pair_clear: cover property (CMP_CLEAR_PULSE);
  c_wre_set: cover property (bus.wr && sel_twc && bus.wdata[`CPD_WRE_BIT] ##1 wre_ff);
  c_dte_kept: cover property (bus.wr && sel_dte && bus.wdata[`CPD_DTE_BIT] ##1 dte_ff);

endmodule : cpd_pwm_deadtime_ctrl
`default_nettype wire

// ==== verif/cpd_pwm_deadtime_ctrl_tb_top.sv ====
// self-checking bench for the channel 3/4 dead-time and waveform control block
`timescale 1ns/100ps
`default_nettype none
`include "cpd_consts.svh"

module cpd_pwm_deadtime_ctrl_tb_top;
  logic        MCLK;
  logic        SYS_RST;
  logic [31:0] ADDR;
  logic [15:0] WDATA;
  logic        WR;
  logic        RD;
  logic        CNT_RUN;
  logic [15:0] RDATA;
  logic        DT_ENABLE;
  logic        CMP_CLEAR_EN;
  logic        WAVE_RETAIN;
  logic        CMP_CLEAR_PULSE;
  logic        COMPL_MODE;
  logic [15:0] COUNT3;
  logic [15:0] COUNT4;
  int          bad_count;
  int          compares;
  int          pulse_cnt;
  logic [15:0] rd_val;

  cpd_pwm_deadtime_ctrl #(.CNT_W(16)) dut (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .CNT_RUN(CNT_RUN), .RDATA(RDATA), .DT_ENABLE(DT_ENABLE), .CMP_CLEAR_EN(CMP_CLEAR_EN),
    .WAVE_RETAIN(WAVE_RETAIN), .CMP_CLEAR_PULSE(CMP_CLEAR_PULSE), .COMPL_MODE(COMPL_MODE),
    .COUNT3(COUNT3), .COUNT4(COUNT4)
  );

  // 250 MHz clock
  initial MCLK = 1'b0;
  always #2 MCLK = ~MCLK;

  // pulses are counted on the edge that samples them, so a one-cycle pulse is never missed
  always @(posedge MCLK) begin
    if (CMP_CLEAR_PULSE === 1'b1) begin
      pulse_cnt <= pulse_cnt + 1;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] off, input logic [15:0] d);
    @(posedge MCLK);
    ADDR  <= `CPD_A_BASE + {24'h000000, off};
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge MCLK);
    WR    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] off, output logic [15:0] d);
    @(posedge MCLK);
    ADDR <= `CPD_A_BASE + {24'h000000, off};
    RD   <= 1'b1;
    @(posedge MCLK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask : rd

  task automatic rd_chk(input logic [7:0] off, input logic [15:0] exp);
    logic [15:0] d;
    rd(off, d);
    check(d, exp);
  endtask : rd_chk

  // clear both counters, select a mode, count for ten edges and compare the outcome
  task automatic run(input logic [7:0] mode, input int exp_pulses, input logic [15:0] exp_cnt);
    wr(8'h10, 16'h0000);
    wr(8'h12, 16'h0000);
    wr(8'h02, {8'h00, mode});
    pulse_cnt = 0;
    @(posedge MCLK);
    CNT_RUN <= 1'b1;
    repeat (10) @(posedge MCLK);
    CNT_RUN <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
    check(16'(pulse_cnt), 16'(exp_pulses));
    check(COUNT3, exp_cnt);
    check(COUNT4, exp_cnt);
    check({15'h0000, COMPL_MODE}, {15'h0000, mode[3:0] >= `CPD_MODE_COMPL_LO});
  endtask : run

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge MCLK);
    bad_count++;
    end_sim();
  end

  // reset value table: offset and expected read data, holes and unmapped places included
  logic [7:0]  tbl_off [13] = '{8'h00, 8'h0A, 8'h0B, 8'h0D, 8'h0F, 8'h10, 8'h11, 8'h14, 8'h16,
                                8'h18, 8'h1E, 8'h20, 8'h30};
  logic [15:0] tbl_exp [13] = '{16'h0000, 16'h00C0, 16'h0000, 16'h0080, 16'h0000, 16'h0000,
                                16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0001, 16'h0000};

  initial begin
    SYS_RST   = 1'b1;
    ADDR      = 32'h00000000;
    WDATA     = 16'h0000;
    WR        = 1'b0;
    RD        = 1'b0;
    CNT_RUN   = 1'b0;
    bad_count = 0;
    compares  = 0;
    pulse_cnt = 0;
    repeat (12) @(posedge MCLK);
    SYS_RST <= 1'b0;
    #1;
    check({15'h0000, DT_ENABLE}, 16'h0001);
    check({15'h0000, CMP_CLEAR_EN}, 16'h0000);
    for (int i = 0; i < 13; i++) begin
      rd_chk(tbl_off[i], tbl_exp[i]);
    end
    // read data fall back to zero one cycle after they stood
    @(posedge MCLK);
    #1 check(RDATA, 16'h0000);
    wr(8'h00, 16'h00A5);
    rd_chk(8'h00, 16'h00A5);
    wr(8'h1A, 16'h1234);
    rd_chk(8'h1A, 16'h1234);
    rd_chk(8'h21, 16'h0000);
    // the table read armed the flag, so a write of one uses the record up first
    wr(8'h20, 16'h0001);
    // unarmed clear and a write of one leave dead time enabled
    wr(8'h20, 16'h0000);
    rd_chk(8'h20, 16'h0001);
    wr(8'h20, 16'h0001);
    // arm by a read, let another register write pass between, then clear
    rd_chk(8'h20, 16'h0001);
    wr(8'h01, 16'h005A);
    wr(8'h20, 16'h0000);
    @(posedge MCLK);
    #1 check({15'h0000, DT_ENABLE}, 16'h0000);
    rd_chk(8'h20, 16'h0000);
    wr(8'h20, 16'h0001);
    rd_chk(8'h20, 16'h0000);
    // an earlier read armed compare clear, so a write of zero drops the record first
    wr(8'h21, 16'h0000);
    // compare clear stays off when written without an arming read
    wr(8'h21, 16'h0080);
    @(posedge MCLK);
    #1 check({15'h0000, CMP_CLEAR_EN}, 16'h0000);
    // dead time is off now, so general_a_ch3 is cycle_data plus one
    wr(8'h16, 16'h0001);
    rd_chk(8'h16, 16'h0001);
    wr(8'h14, 16'h0004);
    wr(8'h18, 16'h0005);
    run(8'h0D, 0, 16'h000A);
    rd_chk(8'h21, 16'h0000);
    wr(8'h21, 16'h0081);
    @(posedge MCLK);
    #1 check({14'h0000, CMP_CLEAR_EN, WAVE_RETAIN}, 16'h0003);
    rd_chk(8'h21, 16'h0081);
    wr(8'h21, 16'h0000);
    rd_chk(8'h21, 16'h0080);
    check({15'h0000, WAVE_RETAIN}, 16'h0000);
    // mode codes 12 to 15, complementary ones clear at the match on general_a_ch3
    for (int m = 12; m < 16; m++) begin
      if (m >= 13) begin
        run(8'(m), 1, 16'h0004);
      end else begin
        run(8'(m), 0, 16'h000A);
      end
    end
    end_sim();
  end
endmodule : cpd_pwm_deadtime_ctrl_tb_top
`default_nettype wire
